// File: rtl/adc_config_control.sv
// converter control: registers, conversion sequencer, compare, pin gating
`timescale 1ns/1ns
`default_nettype none
`include "adc_cfg.svh"

module adc_config_control
  import adc_pkg::*;
(
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  // conversion clock sources and hardware trigger (asynchronous)
  input  wire logic        alt_clk_in,
  input  wire logic        async_clk_in,
  input  wire logic        hw_trigger_in,
  // analog front end: comparator answer and reference limits
  input  wire logic        sar_compare_in,
  input  wire logic        above_ref_high_in,
  input  wire logic        below_ref_low_in,
  output logic      [4:0]  channel_out,
  output logic             sample_out,
  output logic      [9:0]  sar_trial_out,
  output logic             low_power_out,
  // interrupt and pin gating
  output logic             irq_out,
  output logic      [15:0] pin_digital_disable_out
);

  ////////////////////////////////////////////////////////////////////////////
  // registers and signals

  logic [7:0]  config_reg;
  logic [4:0]  trig_cmp_reg;     // trigger, cmp_en, cmp_gt in bits 2:0 (register bits 6:4)
  logic [7:0]  chan_reg;
  logic [9:0]  result_reg;
  logic [9:0]  compare_reg;
  logic [15:0] pin_ctrl_reg;
  logic [7:0]  low_shadow_reg;
  logic        locked_reg;
  logic        active_reg;
  conv_state_t state_reg;
  logic [7:0]  div_cnt_reg;
  logic        ck_tick_reg;
  logic [5:0]  sample_cnt_reg;
  logic [3:0]  step_reg;
  logic [2:0]  settle_reg;
  logic [9:0]  sar_reg;
  logic        start_req_reg;
  logic [2:0]  src_meta_reg;
  logic [2:0]  src_sync_reg;
  logic [2:0]  src_prev_reg;
  logic        trg_meta_reg;
  logic        trg_sync_reg;
  logic        trg_prev_reg;
  logic        cmp_meta_reg;
  logic        cmp_sync_reg;
  logic [1:0]  lim_meta_reg;
  logic [1:0]  lim_sync_reg;
  logic        ack_reg;
  logic [31:0] rdata_next;

  // writes act at the acknowledge edge, when the master sees waitrequest low
  wire logic       wr_en   = avs_write_in && ack_reg;
  wire logic       rd_en   = avs_read_in && !ack_reg;
  wire logic [1:0] mode    = config_reg[`CFG_MODE_HI:`CFG_MODE_LO];
  wire logic       is_10b  = (mode == `MODE_10BIT);
  wire logic       cmp_en  = trig_cmp_reg[1];
  wire logic       cmp_gt  = trig_cmp_reg[0];
  wire logic       hw_trig = trig_cmp_reg[2];
  wire logic       sw_start = wr_en && avs_address_in == `OFF_CHANNEL_STATUS && !hw_trig;

  // divider terminal count: 1, 2, 4 or 8 source ticks per conversion clock
  function automatic logic [7:0] div_limit(input logic [1:0] div);
    div_limit = (8'h01 << div) - 8'h01;
  endfunction : div_limit

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers for asynchronous inputs

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      src_meta_reg <= 3'h0;
      src_sync_reg <= 3'h0;
      src_prev_reg <= 3'h0;
      trg_meta_reg <= 1'b0;
      trg_sync_reg <= 1'b0;
      trg_prev_reg <= 1'b0;
      cmp_meta_reg <= 1'b0;
      cmp_sync_reg <= 1'b0;
      lim_meta_reg <= 2'h0;
      lim_sync_reg <= 2'h0;
    end else begin
      src_meta_reg <= {async_clk_in, alt_clk_in, 1'b0};
      src_sync_reg <= src_meta_reg;
      src_prev_reg <= src_sync_reg;
      trg_meta_reg <= hw_trigger_in;
      trg_sync_reg <= trg_meta_reg;
      trg_prev_reg <= trg_sync_reg;
      cmp_meta_reg <= sar_compare_in;
      cmp_sync_reg <= cmp_meta_reg;
      lim_meta_reg <= {above_ref_high_in, below_ref_low_in};
      lim_sync_reg <= lim_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // conversion clock: source select and divider, one tick per clock period

  logic src_tick;
  always_comb begin
    unique case (config_reg[`CFG_CLK_HI:`CFG_CLK_LO])
      `CLKSRC_BUS: src_tick = 1'b1;
      2'h1:        src_tick = div_cnt_reg[0] == 1'b0 && ck_tick_reg == 1'b0;
      2'h2:        src_tick = src_sync_reg[1] && !src_prev_reg[1];
      2'h3:        src_tick = src_sync_reg[2] && !src_prev_reg[2];
    endcase
  end

  // bus/2 toggles ck_tick_reg and ticks while it and the divider lsb are low; bus ticks every clock, alt and async sources on rising edges
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_cnt_reg <= 8'h00;
      ck_tick_reg <= 1'b0;
    end else begin
      ck_tick_reg <= 1'b0;
      if (config_reg[`CFG_CLK_HI:`CFG_CLK_LO] == 2'h1) begin
        ck_tick_reg <= !ck_tick_reg;
      end
      if (src_tick) begin
        if (div_cnt_reg >= div_limit(config_reg[`CFG_DIV_HI:`CFG_DIV_LO])) begin
          div_cnt_reg <= 8'h00;
        end else begin
          div_cnt_reg <= div_cnt_reg + 8'h01;
        end
      end
    end
  end

  wire logic ck_en = src_tick &&
                     (div_cnt_reg >= div_limit(config_reg[`CFG_DIV_HI:`CFG_DIV_LO]));

  ////////////////////////////////////////////////////////////////////////////
  // pending hardware trigger edge; software starts go straight to the sequencer

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      start_req_reg <= 1'b0;
    end else if (hw_trig && trg_sync_reg && !trg_prev_reg) begin
      start_req_reg <= 1'b1;
    end else if (state_reg == ST_IDLE) begin
      start_req_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer: sample, successive approximation, finish

  wire logic [9:0] full_scale = is_10b ? `FULL_10BIT : `FULL_8BIT;
  logic [9:0] final_code;
  always_comb begin
    if (lim_sync_reg[1]) begin
      final_code = full_scale;
    end else if (lim_sync_reg[0]) begin
      final_code = 10'h000;
    end else begin
      final_code = sar_reg & full_scale;
    end
  end

  wire logic cmp_hit = cmp_gt ? (final_code >= compare_reg)
                              : (final_code < compare_reg);
  wire logic done_ok = (state_reg == ST_FINISH) && (!cmp_en || cmp_hit);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg      <= ST_IDLE;
      sample_cnt_reg <= 6'h00;
      step_reg       <= 4'h0;
      sar_reg        <= 10'h000;
      settle_reg     <= 3'h0;
      active_reg     <= 1'b0;
    end else if (sw_start) begin
      // a software start abandons any running conversion and begins afresh
      state_reg      <= ST_SAMPLE;
      sample_cnt_reg <= 6'h00;
      active_reg     <= 1'b1;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (start_req_reg) begin
            state_reg      <= ST_SAMPLE;
            sample_cnt_reg <= 6'h00;
            active_reg     <= 1'b1;
          end
        end
        ST_SAMPLE: begin
          // two ticks per cycle from zero round the odd half counts up to 4 and 24 whole cycles
          if (ck_en) begin
            sample_cnt_reg <= sample_cnt_reg + 6'h02;
            if (sample_cnt_reg + 6'h02 >= (config_reg[`CFG_LONG_SAMPLE_BIT] ?
                `SAMPLE_LONG_HALVES : `SAMPLE_SHORT_HALVES)) begin
              state_reg <= ST_CONVERT;
              step_reg   <= is_10b ? `STEPS_10BIT : `STEPS_8BIT;
              sar_reg    <= 10'h000;
              settle_reg <= 3'h0;
            end
          end
        end
        ST_CONVERT: begin
          // the comparator answer lags the trial code by the output and sync flops
          if (settle_reg != `SAR_SETTLE) begin
            settle_reg <= settle_reg + 3'h1;
          end else if (ck_en) begin
            if (!cmp_sync_reg) begin
              sar_reg[step_reg - 4'h1] <= 1'b1;
            end
            settle_reg <= 3'h0;
            step_reg <= step_reg - 4'h1;
            if (step_reg == 4'h1) begin
              state_reg <= ST_FINISH;
            end
          end
        end
        ST_FINISH: begin
          // continuous mode goes straight back to sampling unless a hardware trigger is pending
          if (chan_reg[`CS_CONT_BIT] && !start_req_reg) begin
            state_reg      <= ST_SAMPLE;
            sample_cnt_reg <= 6'h00;
          end else begin
            state_reg  <= ST_IDLE;
            active_reg <= 1'b0;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // result hold: the low byte is frozen by a high-byte read

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      result_reg     <= 10'h000;
      locked_reg     <= 1'b0;
      low_shadow_reg <= 8'h00;
    end else begin
      if (done_ok && !locked_reg) begin
        result_reg <= final_code;
      end
      if (rd_en && avs_address_in == `OFF_RESULT_HIGH) begin
        locked_reg     <= 1'b1;
        low_shadow_reg <= result_reg[7:0];
      end else if (rd_en && avs_address_in == `OFF_RESULT_LOW) begin
        locked_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software registers

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      config_reg   <= `RST_CONVERTER_CONFIG;
      trig_cmp_reg <= 5'(`RST_TRIGGER_COMPARE);
      compare_reg  <= 10'h000;
      pin_ctrl_reg <= 16'h0000;
    end else if (wr_en) begin
      unique case (avs_address_in)
        `OFF_CONVERTER_CONFIG:   config_reg        <= avs_writedata_in[7:0];
        `OFF_TRIGGER_COMPARE:    trig_cmp_reg[2:0] <= avs_writedata_in[6:4];
        `OFF_COMPARE_HIGH:       compare_reg[9:8]  <= avs_writedata_in[1:0];
        `OFF_COMPARE_LOW:        compare_reg[7:0]  <= avs_writedata_in[7:0];
        `OFF_PIN_CONTROL_FIRST:  pin_ctrl_reg[7:0] <= avs_writedata_in[7:0];
        `OFF_PIN_CONTROL_SECOND: pin_ctrl_reg[15:8] <= avs_writedata_in[7:0];
        default: ;
      endcase
    end
  end

  // channel register: complete flag set by hardware wins over write clear
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      chan_reg <= `RST_CHANNEL_STATUS;
    end else begin
      if (wr_en && avs_address_in == `OFF_CHANNEL_STATUS) begin
        chan_reg[6:0] <= avs_writedata_in[6:0];
        chan_reg[`CS_COMPLETE_BIT] <= 1'b0;
      end
      if (done_ok) begin
        chan_reg[`CS_COMPLETE_BIT] <= 1'b1;
      end else if (rd_en && avs_address_in == `OFF_RESULT_LOW) begin
        chan_reg[`CS_COMPLETE_BIT] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus read mux and single-wait answer

  always_comb begin
    rdata_next = 32'h0000_0000;
    unique case (avs_address_in)
      `OFF_CONVERTER_CONFIG:   rdata_next[7:0] = config_reg;
      `OFF_TRIGGER_COMPARE:    rdata_next[7:0] = {active_reg, trig_cmp_reg[2:0], 4'h0};
      `OFF_CHANNEL_STATUS:     rdata_next[7:0] = chan_reg;
      `OFF_RESULT_HIGH:        rdata_next[7:0] = {6'h00, result_reg[9:8]};
      `OFF_RESULT_LOW:         rdata_next[7:0] = locked_reg ? low_shadow_reg : result_reg[7:0];
      `OFF_COMPARE_HIGH:       rdata_next[7:0] = {6'h00, compare_reg[9:8]};
      `OFF_COMPARE_LOW:        rdata_next[7:0] = compare_reg[7:0];
      `OFF_PIN_CONTROL_FIRST:  rdata_next[7:0] = pin_ctrl_reg[7:0];
      `OFF_PIN_CONTROL_SECOND: rdata_next[7:0] = pin_ctrl_reg[15:8];
      default:                 rdata_next = 32'h0000_0000;
    endcase
  end

  // every access waits one cycle so read data come from a flip-flop
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack_reg          <= 1'b0;
      avs_readdata_out <= 32'h0000_0000;
    end else begin
      ack_reg <= (avs_read_in || avs_write_in) && !ack_reg;
      if (rd_en) begin
        avs_readdata_out <= rdata_next;
      end
    end
  end

  always_comb avs_waitrequest_out = !ack_reg;

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs to the front end, pins and interrupt

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      channel_out             <= 5'h1f;
      sample_out              <= 1'b0;
      sar_trial_out           <= 10'h000;
      low_power_out           <= 1'b0;
      irq_out                 <= 1'b0;
      pin_digital_disable_out <= 16'h0000;
    end else begin
      channel_out             <= chan_reg[`CS_CHAN_HI:`CS_CHAN_LO];
      sample_out              <= (state_reg == ST_SAMPLE);
      sar_trial_out           <= sar_reg | ((state_reg == ST_CONVERT && step_reg != 4'h0) ?
                                 (10'h001 << (step_reg - 4'h1)) : 10'h000);
      low_power_out           <= config_reg[`CFG_LOW_POWER_BIT];
      irq_out                 <= chan_reg[`CS_COMPLETE_BIT] && chan_reg[`CS_IRQ_EN_BIT];
      pin_digital_disable_out <= pin_ctrl_reg;
    end
  end

endmodule : adc_config_control
`default_nettype wire

// File: rtl/adc_cfg.svh
// register offsets, field positions, reset values and timing counts of the converter control
`ifndef ADC_CFG_SVH
`define ADC_CFG_SVH

// register word addresses (consecutive offsets)
`define OFF_CONVERTER_CONFIG   4'h0
`define OFF_TRIGGER_COMPARE    4'h1
`define OFF_CHANNEL_STATUS     4'h2
`define OFF_RESULT_HIGH        4'h3
`define OFF_RESULT_LOW         4'h4
`define OFF_COMPARE_HIGH       4'h5
`define OFF_COMPARE_LOW        4'h6
`define OFF_PIN_CONTROL_FIRST  4'h7
`define OFF_PIN_CONTROL_SECOND 4'h8

// converter_config fields
`define CFG_LOW_POWER_BIT      7
`define CFG_DIV_HI             6
`define CFG_DIV_LO             5
`define CFG_LONG_SAMPLE_BIT    4
`define CFG_MODE_HI            3
`define CFG_MODE_LO            2
`define CFG_CLK_HI             1
`define CFG_CLK_LO             0

// trigger_compare_ctrl fields
`define TC_ACTIVE_BIT          7
`define TC_TRIGGER_BIT         6
`define TC_CMP_EN_BIT          5
`define TC_CMP_GT_BIT          4

// channel_status_ctrl fields
`define CS_COMPLETE_BIT        7
`define CS_IRQ_EN_BIT          6
`define CS_CONT_BIT            5
`define CS_CHAN_HI             4
`define CS_CHAN_LO             0

// encodings
`define MODE_10BIT             2'h2
`define CLKSRC_BUS             2'h0
`define FULL_10BIT             10'h3ff
`define FULL_8BIT              10'h0ff

// reset values
`define RST_CONVERTER_CONFIG   8'h00
`define RST_TRIGGER_COMPARE    8'h00
`define RST_CHANNEL_STATUS     8'h1f

// sampling phase in half conversion-clock cycles: 3.5 and 23.5 cycles
`define SAMPLE_SHORT_HALVES    6'h07
`define SAMPLE_LONG_HALVES     6'h2f
// successive approximation steps per mode
`define STEPS_10BIT            4'ha
`define STEPS_8BIT             4'h8
// clocks from a new trial code until its comparator answer has passed the synchroniser
`define SAR_SETTLE             3'h3

`endif

// File: rtl/adc_pkg.sv
// types shared by the converter control logic
package adc_pkg;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SAMPLE,
    ST_CONVERT,
    ST_FINISH
  } conv_state_t;
endpackage : adc_pkg

// File: verification/adc_config_control_props.sv
// port assertions for the converter control block
`timescale 1ns/1ns
`default_nettype none
module adc_config_control_props (
  // clock and reset
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  // register bus
  input wire logic [3:0]  avs_address_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic        avs_waitrequest_out,
  // converter side
  input wire logic [4:0]  channel_out,
  input wire logic        sample_out,
  input wire logic        low_power_out,
  input wire logic        irq_out,
  input wire logic [15:0] pin_digital_disable_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  ////////////////////////////////////////
  // accepted accesses, flagged in the acknowledge cycle
  wire logic ack     = !avs_waitrequest_out;
  wire logic bus_act = avs_read_in || avs_write_in;
  wire logic cfg_wr  = ack && avs_write_in && avs_address_in == 4'h0;
  wire logic chan_wr = ack && avs_write_in && avs_address_in == 4'h2;
  wire logic pin_wr  = ack && avs_write_in && avs_address_in == 4'h7;
  wire logic pin2_wr = ack && avs_write_in && avs_address_in == 4'h8;
  wire logic trig_rd = ack && avs_read_in && avs_address_in == 4'h1;
  // a taken request is answered in the next cycle, for one cycle only
  sequence req_taken;
    bus_act && avs_waitrequest_out;
  endsequence
  sequence one_ack;
    !avs_waitrequest_out ##1 avs_waitrequest_out;
  endsequence
  wait_ack_a: assert property (req_taken |=> one_ack)
    else $error("bus answer out of step");
  ////////////////////////////////////////
  // fields reach their ports from the write edge; channel and pin gating change at no other time
  cfg_power_a: assert property (cfg_wr |=> ##1 low_power_out == $past(avs_writedata_in[7], 2))
    else $error("low power bit not taken");
  chan_set_a: assert property (chan_wr |=> ##1 channel_out == $past(avs_writedata_in[4:0], 2))
    else $error("channel not taken");
  chan_hold_a: assert property ($changed(channel_out) |-> $past(chan_wr, 2))
    else $error("channel moved without a write");
  pin_set_a: assert property (pin_wr |=> ##1 pin_digital_disable_out[7:0] == $past(avs_writedata_in[7:0], 2))
    else $error("pin control not taken");
  pin_hold_a: assert property ($changed(pin_digital_disable_out) |-> $past(pin_wr, 2) || $past(pin2_wr, 2))
    else $error("pin gating moved without a write");
  trig_zero_a: assert property (trig_rd |-> avs_readdata_out[3:2] == 2'b00)
    else $error("unimplemented bits read nonzero");
  // sampling never shorter than four conversion clocks, which are never faster than clk_in
  sample_min_a: assert property ($rose(sample_out) |-> sample_out [*4])
    else $error("sampling phase too short");
  // the request line drops only after software clears the flag or the enable
  irq_fall_a: assert property ($fell(irq_out) |-> $past(bus_act) || $past(bus_act, 2) || $past(bus_act, 3))
    else $error("interrupt dropped on its own");
endmodule : adc_config_control_props

bind adc_config_control adc_config_control_props u_props (
  .clk_in, .rst_n_in, .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
  .avs_readdata_out, .avs_waitrequest_out, .channel_out, .sample_out, .low_power_out,
  .irq_out, .pin_digital_disable_out
);
`default_nettype wire

// File: verification/tb_adc_config_control.sv
// self-checking bench for the converter control block
`timescale 1ns/1ns
`default_nettype none
module tb_adc_config_control;
  logic        clk_in;
  logic        rst_n_in = 1'b0, rd = 1'b0, wr = 1'b0, hw_trig = 1'b0, hi = 1'b0, lo = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic [9:0]  ana = 10'h0;
  logic [31:0] seed = 32'h7a7718e4;
  logic        wreq, smp, lp, irq;
  logic [31:0] rdata;
  logic [4:0]  chan;
  logic [9:0]  trial;
  logic [15:0] pins;
  logic [7:0]  q;
  int          miscompares = 0, num_checks = 0, scnt = 0, slen = 0;
  // comparator of the analog front end: high when the trial code overshoots the input
  wire logic   cmp = trial > ana;

  adc_config_control uut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .avs_address_in(addr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wdata), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wreq), .alt_clk_in(1'b0), .async_clk_in(1'b0),
    .hw_trigger_in(hw_trig), .sar_compare_in(cmp), .above_ref_high_in(hi),
    .below_ref_low_in(lo), .channel_out(chan), .sample_out(smp), .sar_trial_out(trial),
    .low_power_out(lp), .irq_out(irq), .pin_digital_disable_out(pins)
  );
  ////////////////////////////////////////
  // 250 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  // length of the last sampling phase in clock cycles
  always @(posedge clk_in) begin
    if (smp === 1'b1) begin
      scnt <= scnt + 1;
    end else if (scnt != 0) begin
      slen <= scnt;
      scnt <= 0;
    end
  end
  ////////////////////////////////////////
  // reporting
  task automatic fail(input string m);
    miscompares++;
    $display("[FAIL] %0t %s", $time, m);
  endtask : fail
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  task automatic sig(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) fail($sformatf("port %h expected %h", g, e));
  endtask : sig
  // reference model: clamp at the references, else the input code
  function automatic int model(input logic [9:0] a, input logic h, input logic l, input logic ten);
    if (h) return ten ? 32'h3ff : 32'hff;
    if (l) return 0;
    return int'(a);
  endfunction : model
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  ////////////////////////////////////////
  // one bus access; an idle edge first keeps a release and the next request apart
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [7:0] r);
    int n = 0;
    @(posedge clk_in);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= {24'h000000, d};
    do begin
      @(posedge clk_in);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    r = rdata[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 50) begin
      fail("bus access not answered");
      report_and_stop();
    end
  endtask : bus
  task automatic wr8(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] r;
    bus(1'b1, a, d, r);
  endtask : wr8
  task automatic chk(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] r;
    bus(1'b0, a, 8'h00, r);
    num_checks++;
    if (r !== e) fail($sformatf("read %h gave %h expected %h", a, r, e));
  endtask : chk
  // read until bit 7 shows v; bounded since a dead sequencer would hang here
  task automatic poll(input logic [3:0] a, input logic v);
    logic [7:0] r;
    int n = 0;
    do begin
      bus(1'b0, a, 8'h00, r);
      n++;
    end while (r[7] !== v && n < 300);
    if (n >= 300) begin
      fail("status bit never reached");
      report_and_stop();
    end
  endtask : poll
  // high byte first so the pair stays together
  task automatic res(input logic ten);
    int e;
    e = model(ana, hi, lo, ten);
    chk(4'h3, 8'(e >> 8));
    chk(4'h4, 8'(e));
  endtask : res
  ////////////////////////////////////////
  // main sequence
  initial begin
    repeat (20) @(posedge clk_in);
    rst_n_in <= 1'b1;
    chk(4'h0, 8'h00);
    chk(4'h2, 8'h1f);
    wr8(4'h0, 8'h98);
    chk(4'h0, 8'h98);
    sig(16'(lp), 16'h1);
    wr8(4'h1, 8'hfc);
    chk(4'h1, 8'h70);
    wr8(4'h1, 8'h00);
    wr8(4'h8, 8'h00);
    wr8(4'h7, 8'h02);
    repeat (2) @(posedge clk_in);
    sig(pins, 16'h0002);
    wr8(4'hf, 8'hff);
    chk(4'hf, 8'h00);
    // single conversions on channels 1 to 6, channel 1 at full scale with its pin gated, the others at random inputs
    for (int i = 0; i < 6; i++) begin
      ana <= (i == 0) ? 10'h3ff : 10'(xs());
      wr8(4'h0, {3'b100, i[0], 4'h8});
      wr8(4'h2, {1'b0, i[1], 1'b0, 5'(i + 1)});
      chk(4'h1, 8'h80);
      sig(16'(chan), 16'(i + 1));
      poll(4'h2, 1'b1);
      @(posedge clk_in);
      sig(16'(irq), 16'(i[1]));
      sig(16'(slen), i[0] ? 16'h18 : 16'h4);
      res(1'b1);
      chk(4'h2, {1'b0, i[1], 1'b0, 5'(i + 1)});
    end
    // clamping at both references, the high one at both resolutions
    for (int m = 0; m < 3; m++) begin
      hi <= (m < 2);
      lo <= (m == 2);
      wr8(4'h0, m == 1 ? 8'h90 : 8'h98);
      wr8(4'h2, 8'h01);
      poll(4'h2, 1'b1);
      res(m != 1);
    end
    lo <= 1'b0;
    // compare in both directions, met and missed
    wr8(4'h5, 8'h02);
    wr8(4'h6, 8'h00);
    for (int k = 0; k < 4; k++) begin
      ana <= k[0] ? 10'h300 : 10'h100;
      wr8(4'h1, {3'b001, !k[1], 4'h0});
      wr8(4'h2, 8'h01);
      poll(4'h1, 1'b0);
      chk(4'h2, {k[0] ^ k[1], 7'h01});
      if (k == 0) chk(4'h3, 8'h00);
      if (k == 0) chk(4'h4, 8'h00);
      else bus(1'b0, 4'h4, 8'h00, q);
    end
    // result pair held between the high and low reads
    wr8(4'h1, 8'h00);
    ana <= 10'h1c3;
    wr8(4'h2, 8'h01);
    poll(4'h2, 1'b1);
    chk(4'h3, 8'h01);
    ana <= 10'h23c;
    wr8(4'h2, 8'h01);
    poll(4'h1, 1'b0);
    chk(4'h4, 8'hc3);
    // continuous conversions follow a changing input
    wr8(4'h2, 8'h21);
    poll(4'h2, 1'b1);
    res(1'b1);
    ana <= 10'h0a7;
    poll(4'h2, 1'b1);
    bus(1'b0, 4'h4, 8'h00, q);
    poll(4'h2, 1'b1);
    res(1'b1);
    // single mode converts once only
    wr8(4'h2, 8'h01);
    poll(4'h1, 1'b0);
    bus(1'b0, 4'h4, 8'h00, q);
    repeat (80) @(posedge clk_in);
    chk(4'h2, 8'h01);
    // hardware trigger: a channel write alone starts nothing
    wr8(4'h1, 8'h40);
    wr8(4'h2, 8'h01);
    repeat (80) @(posedge clk_in);
    chk(4'h2, 8'h01);
    hw_trig <= 1'b1;
    poll(4'h2, 1'b1);
    res(1'b1);
    report_and_stop();
  end
endmodule : tb_adc_config_control
`default_nettype wire
